// >>> design/fp_post_exc_pkg.sv
/*
 Constants and types for the post-result floating-point exception check.
 Assumes a single core clock and a datapath that hands over a result
 rounded to destination precision with an unbounded exponent.
*/
`default_nettype none

package fp_post_exc_pkg;

	localparam int EXP_W = 18;

	typedef logic signed [EXP_W-1:0] exp_t;

	typedef enum logic [1:0] {FMT_HALF, FMT_SINGLE, FMT_DOUBLE, FMT_EXT} fmt_t;

	typedef enum logic [1:0] {RND_NEAREST, RND_DOWN, RND_UP, RND_ZERO} rmode_t;

	typedef enum logic [2:0] {
		RES_ROUNDED,
		RES_INF,
		RES_MAX_FINITE,
		RES_BIASED,
		RES_DENORM,
		RES_NONE
	} res_kind_t;

	// overflow when unbiased exponent of 1.f reaches these
	localparam exp_t OVF_EXP_HALF   = 18'sh00010;  // 16
	localparam exp_t OVF_EXP_SINGLE = 18'sh00080;  // 128
	localparam exp_t OVF_EXP_DOUBLE = 18'sh00400;  // 1024
	localparam exp_t OVF_EXP_EXT    = 18'sh04000;  // 16384

	// tiny when unbiased exponent falls below these
	localparam exp_t TINY_EXP_HALF   = -18'sh0000E;  // -14
	localparam exp_t TINY_EXP_SINGLE = -18'sh0007E;  // -126
	localparam exp_t TINY_EXP_DOUBLE = -18'sh003FE;  // -1022
	localparam exp_t TINY_EXP_EXT    = -18'sh03FFE;  // -16382

	localparam exp_t BIAS_ADJ_DEFAULT = 18'sh06000;

	localparam int FLAG_OVF = 0;
	localparam int FLAG_UNF = 1;
	localparam int FLAG_PRE = 2;
	localparam logic [2:0] FLAGS_RESET = 3'h0;

endpackage : fp_post_exc_pkg

`default_nettype wire

// >>> design/fp_exp_threshold.sv
/*
 Per-format overflow and tiny detection on an unbounded exponent.
 Assumes the significand is normalized 1.f, so the exponent alone decides.
*/
`default_nettype none

module fp_exp_threshold
(
	// result
	input  wire fp_post_exc_pkg::fmt_t i_fmt,
	input  wire fp_post_exc_pkg::exp_t i_exp,
	input  wire logic                  i_zero,
	// verdict
	output logic                       o_overflow,
	output logic                       o_tiny,
	output fp_post_exc_pkg::exp_t      o_ovf_exp,
	output fp_post_exc_pkg::exp_t      o_tiny_exp
);

	always_comb
	begin
		case (i_fmt)
			fp_post_exc_pkg::FMT_HALF:
			begin
				o_ovf_exp  = fp_post_exc_pkg::OVF_EXP_HALF;
				o_tiny_exp = fp_post_exc_pkg::TINY_EXP_HALF;
			end
			fp_post_exc_pkg::FMT_SINGLE:
			begin
				o_ovf_exp  = fp_post_exc_pkg::OVF_EXP_SINGLE;
				o_tiny_exp = fp_post_exc_pkg::TINY_EXP_SINGLE;
			end
			fp_post_exc_pkg::FMT_DOUBLE:
			begin
				o_ovf_exp  = fp_post_exc_pkg::OVF_EXP_DOUBLE;
				o_tiny_exp = fp_post_exc_pkg::TINY_EXP_DOUBLE;
			end
			default:
			begin
				o_ovf_exp  = fp_post_exc_pkg::OVF_EXP_EXT;
				o_tiny_exp = fp_post_exc_pkg::TINY_EXP_EXT;
			end
		endcase
	end

	// at-or-beyond for overflow, strictly below for tiny
	assign o_overflow = !i_zero && (i_exp >= o_ovf_exp);
	assign o_tiny     = !i_zero && (i_exp < o_tiny_exp);

endmodule : fp_exp_threshold

`default_nettype wire

// >>> design/fp_ovf_default.sv
/*
 Masked overflow default selection from rounding mode and true sign.
 Assumes the caller only uses the answer on a masked overflow.
*/
`default_nettype none

module fp_ovf_default
(
	// selection
	input  wire fp_post_exc_pkg::rmode_t i_rmode,
	input  wire logic                    i_sign,
	// answer
	output fp_post_exc_pkg::res_kind_t   o_kind
);

	always_comb
	begin
		case (i_rmode)
			fp_post_exc_pkg::RND_NEAREST:
				o_kind = fp_post_exc_pkg::RES_INF;
			fp_post_exc_pkg::RND_DOWN:
				o_kind = i_sign ? fp_post_exc_pkg::RES_INF
					: fp_post_exc_pkg::RES_MAX_FINITE;
			fp_post_exc_pkg::RND_UP:
				o_kind = i_sign ? fp_post_exc_pkg::RES_MAX_FINITE
					: fp_post_exc_pkg::RES_INF;
			default:
				o_kind = fp_post_exc_pkg::RES_MAX_FINITE;
		endcase
	end

endmodule : fp_ovf_default

`default_nettype wire

// >>> design/fp_post_result_exception_check.sv
/*
 Post-computation exception check: overflow, underflow and inexact.
 Takes a rounded result with unbounded exponent plus the datapath's
 inexact indication, and returns the value to store, per-operation
 flags, sticky flags and a handler request one cycle later.
 Assumes inputs come from logic on i_clk; no synchronisers needed.
*/
`default_nettype none

module fp_post_result_exception_check
#(
	parameter int                    SIG_W    = 64,
	parameter fp_post_exc_pkg::exp_t BIAS_ADJ = fp_post_exc_pkg::BIAS_ADJ_DEFAULT
)
(
	// clock and control
	input  wire logic                    i_clk,
	input  wire logic                    i_reset_n,
	input  wire logic                    i_ce,
	// operation completion from rounding datapath
	input  wire logic                    i_valid,
	input  wire fp_post_exc_pkg::fmt_t   i_fmt,
	input  wire fp_post_exc_pkg::rmode_t i_rmode,
	input  wire logic                    i_stack_unit,
	input  wire logic                    i_dest_mem,
	input  wire logic                    i_sign,
	input  wire logic                    i_zero,
	input  wire fp_post_exc_pkg::exp_t   i_exp,
	input  wire logic [SIG_W-1:0]        i_sig,
	input  wire logic                    i_inexact,
	// masks, set means default response
	input  wire logic                    i_mask_overflow,
	input  wire logic                    i_mask_underflow,
	input  wire logic                    i_mask_precision,
	// software clear of sticky flags, one bit per flag
	input  wire logic [2:0]              i_clear_flags,
	// stored result
	output logic                         o_res_valid,
	output logic                         o_res_write,
	output fp_post_exc_pkg::res_kind_t   o_res_kind,
	output logic                         o_res_sign,
	output fp_post_exc_pkg::exp_t        o_res_exp,
	output logic [SIG_W-1:0]             o_res_sig,
	// this operation's flags and dispatch
	output logic                         o_op_overflow,
	output logic                         o_op_underflow,
	output logic                         o_op_precision,
	output logic                         o_handler_req,
	output logic                         o_clear_cond_code_bit_one,
	// sticky flags
	output logic                         o_overflow_flag,
	output logic                         o_underflow_flag,
	output logic                         o_precision_flag
);

	logic                        ovf;
	logic                        tiny;
	fp_post_exc_pkg::exp_t       ovf_exp;
	fp_post_exc_pkg::exp_t       tiny_exp;
	fp_post_exc_pkg::res_kind_t  ovf_kind;

	logic                        unf_report;
	logic                        ovf_trap;
	logic                        unf_trap;
	logic                        mem_trap;
	logic                        pre_report;
	logic                        handler;

	fp_post_exc_pkg::exp_t       unf_dist;
	logic [SIG_W-1:0]            denorm_sig;

	fp_post_exc_pkg::res_kind_t  next_kind;
	logic                        next_write;
	fp_post_exc_pkg::exp_t       next_exp;
	logic [SIG_W-1:0]            next_sig;
	logic [2:0]                  set_flags;
	logic [2:0]                  sticky;

	fp_exp_threshold u_threshold
	(
		.i_fmt      (i_fmt),
		.i_exp      (i_exp),
		.i_zero     (i_zero),
		.o_overflow (ovf),
		.o_tiny     (tiny),
		.o_ovf_exp  (ovf_exp),
		.o_tiny_exp (tiny_exp)
	);

	fp_ovf_default u_ovf_default
	(
		.i_rmode (i_rmode),
		.i_sign  (i_sign),
		.o_kind  (ovf_kind)
	);

	// classification; overflow outranks underflow, they cannot coexist
	assign ovf_trap   = ovf && !i_mask_overflow;
	assign unf_report = tiny && (i_mask_underflow ? i_inexact : 1'b1);
	assign unf_trap   = unf_report && !i_mask_underflow;
	assign mem_trap   = (ovf_trap || unf_trap) && i_dest_mem;

	// a trapped store to memory drops the inexact report
	assign pre_report = i_inexact && !mem_trap;

	assign handler = ovf_trap || unf_trap
		|| (pre_report && !i_mask_precision);

	// denormalize by shifting; bits lost here are not re-rounded,
	// the datapath's inexact must already cover them
	assign unf_dist   = fp_post_exc_pkg::exp_t'(tiny_exp - i_exp);
	assign denorm_sig = (unf_dist >= fp_post_exc_pkg::exp_t'(SIG_W)) ? '0
		: (i_sig >> unf_dist);

	always_comb
	begin
		next_kind  = fp_post_exc_pkg::RES_ROUNDED;
		next_write = 1'b1;
		next_exp   = i_exp;
		next_sig   = i_sig;
		if (ovf && i_mask_overflow)
		begin
			next_kind = ovf_kind;
			if (ovf_kind == fp_post_exc_pkg::RES_INF)
			begin
				next_exp = ovf_exp;
				next_sig = '0;
			end
			else
			begin
				next_exp = fp_post_exc_pkg::exp_t'(ovf_exp - 18'sh00001);
				next_sig = '1;
			end
		end
		else if (ovf_trap || unf_trap)
		begin
			// vector unit or memory destination keeps operands; stack unit to register stores biased value
			if (i_stack_unit && !i_dest_mem)
			begin
				next_kind = fp_post_exc_pkg::RES_BIASED;
				next_exp  = ovf_trap
					? fp_post_exc_pkg::exp_t'(i_exp - BIAS_ADJ)
					: fp_post_exc_pkg::exp_t'(i_exp + BIAS_ADJ);
			end
			else
			begin
				next_kind  = fp_post_exc_pkg::RES_NONE;
				next_write = 1'b0;
			end
		end
		else if (tiny)
		begin
			// masked: stored whether exact or not
			next_kind = fp_post_exc_pkg::RES_DENORM;
			next_exp  = tiny_exp;
			next_sig  = denorm_sig;
		end
	end

	assign set_flags = i_valid ? {pre_report, unf_report, ovf} : 3'h0;

	// result register
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			o_res_write <= 1'b0;
			o_res_kind  <= fp_post_exc_pkg::RES_NONE;
			o_res_sign  <= 1'b0;
			o_res_exp   <= '0;
			o_res_sig   <= '0;
		end
		else if (i_ce && i_valid)
		begin
			o_res_write <= next_write;
			o_res_kind  <= next_kind;
			o_res_sign  <= i_sign;
			o_res_exp   <= next_exp;
			o_res_sig   <= next_sig;
		end
	end

	// per-operation flags and strobes, all qualified by completion
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			o_res_valid               <= 1'b0;
			o_op_overflow             <= 1'b0;
			o_op_underflow            <= 1'b0;
			o_op_precision            <= 1'b0;
			o_handler_req             <= 1'b0;
			o_clear_cond_code_bit_one <= 1'b0;
		end
		else if (i_ce)
		begin
			o_res_valid               <= i_valid;
			o_op_overflow             <= set_flags[fp_post_exc_pkg::FLAG_OVF];
			o_op_underflow            <= set_flags[fp_post_exc_pkg::FLAG_UNF];
			o_op_precision            <= set_flags[fp_post_exc_pkg::FLAG_PRE];
			o_handler_req             <= i_valid && handler;
			o_clear_cond_code_bit_one <= i_valid && mem_trap;
		end
	end

	// sticky flags; a set in the clearing cycle wins
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
			sticky <= fp_post_exc_pkg::FLAGS_RESET;
		else if (i_ce)
			sticky <= (sticky & ~i_clear_flags) | set_flags;
	end

	assign o_overflow_flag  = sticky[fp_post_exc_pkg::FLAG_OVF];
	assign o_underflow_flag = sticky[fp_post_exc_pkg::FLAG_UNF];
	assign o_precision_flag = sticky[fp_post_exc_pkg::FLAG_PRE];

	// checks

	default clocking cb @(posedge i_clk);
	endclocking

	default disable iff (!i_reset_n);

	logic go;
	assign go = i_ce && i_valid;

	a_ovf_half_single: assert property (
		go && !i_zero && i_fmt inside {fp_post_exc_pkg::FMT_HALF, fp_post_exc_pkg::FMT_SINGLE}
		|=> o_op_overflow == $past(i_exp >= ((i_fmt == fp_post_exc_pkg::FMT_HALF)
			? 18'sh00010 : 18'sh00080)))
		else $error("overflow threshold wrong for half or single");

	a_ovf_double_ext: assert property (
		go && !i_zero && i_fmt inside {fp_post_exc_pkg::FMT_DOUBLE, fp_post_exc_pkg::FMT_EXT}
		|=> o_op_overflow == $past(i_exp >= ((i_fmt == fp_post_exc_pkg::FMT_DOUBLE)
			? 18'sh00400 : 18'sh04000)))
		else $error("overflow threshold wrong for double or extended");

	a_ovf_nearest_inf: assert property (
		go && ovf && i_mask_overflow && i_rmode == fp_post_exc_pkg::RND_NEAREST
		|=> o_res_kind == fp_post_exc_pkg::RES_INF && o_res_sign == $past(i_sign)
			&& o_overflow_flag)
		else $error("masked overflow to nearest not signed infinity");

	a_ovf_directed: assert property (
		go && ovf && i_mask_overflow && i_rmode == fp_post_exc_pkg::RND_DOWN
		|=> o_res_kind == ($past(i_sign) ? fp_post_exc_pkg::RES_INF
			: fp_post_exc_pkg::RES_MAX_FINITE))
		else $error("masked overflow toward minus infinity wrong");

	a_ovf_trap_req: assert property (
		go && ovf && !i_mask_overflow && !i_stack_unit
		|=> o_handler_req && !o_res_write ##1 (!o_handler_req || $past(i_valid) || !$past(i_ce)))
		else $error("unmasked vector overflow must trap and keep destination");

	a_tiny_single: assert property (
		go && !i_zero && i_fmt == fp_post_exc_pkg::FMT_SINGLE && !i_mask_underflow
		|=> o_op_underflow == $past(i_exp < -18'sh0007E))
		else $error("single tiny threshold wrong");

	a_tiny_ext: assert property (
		go && !i_zero && i_fmt == fp_post_exc_pkg::FMT_EXT && !i_mask_underflow
		|=> o_op_underflow == $past(i_exp < -18'sh03FFE))
		else $error("extended tiny threshold wrong");

	a_unf_masked_exact: assert property (
		go && tiny && i_mask_underflow && !i_inexact
		|=> !o_op_underflow && o_res_kind == fp_post_exc_pkg::RES_DENORM
			&& o_res_exp == $past(tiny_exp))
		else $error("exact tiny under mask must not flag underflow");

	a_unf_trap_stack: assert property (
		go && tiny && !i_mask_underflow && i_stack_unit && !i_dest_mem
		|=> o_handler_req && o_op_underflow && o_res_kind == fp_post_exc_pkg::RES_BIASED
			&& o_res_exp == $past(i_exp) + BIAS_ADJ)
		else $error("unmasked stack underflow must store biased result");

	a_inexact_trap: assert property (
		go && i_inexact && !ovf && !tiny && !i_mask_precision
		|=> o_op_precision && o_handler_req && o_res_kind == fp_post_exc_pkg::RES_ROUNDED)
		else $error("unmasked inexact must flag, store and trap");

	a_mem_trap_cc: assert property (
		go && i_dest_mem && ovf && !i_mask_overflow
		|=> !o_op_precision && o_clear_cond_code_bit_one)
		else $error("trapped store must drop inexact and clear cc bit");

	a_sticky_hold: assert property (
		i_ce && o_precision_flag && !i_clear_flags[2]
		|=> o_precision_flag)
		else $error("precision flag lost without clear");

	a_req_strobe: assert property (
		o_handler_req |-> o_res_valid && (o_op_overflow || o_op_underflow || o_op_precision))
		else $error("handler request without completion or flag");

	a_ovf_up_mirror: assert property (
		go && ovf && i_mask_overflow && i_rmode == fp_post_exc_pkg::RND_UP
		|=> o_res_kind == ($past(i_sign) ? fp_post_exc_pkg::RES_MAX_FINITE
			: fp_post_exc_pkg::RES_INF))
		else $error("masked overflow toward plus infinity wrong");

	a_ovf_zero_max: assert property (
		go && ovf && i_mask_overflow && i_rmode == fp_post_exc_pkg::RND_ZERO
		|=> o_res_kind == fp_post_exc_pkg::RES_MAX_FINITE && o_res_sign == $past(i_sign)
			&& o_res_sig == '1)
		else $error("masked overflow toward zero not largest finite");

	a_tiny_half: assert property (
		go && !i_zero && i_fmt == fp_post_exc_pkg::FMT_HALF && !i_mask_underflow
		|=> o_op_underflow == $past(i_exp < -18'sh0000E))
		else $error("half tiny threshold wrong");

	a_tiny_double: assert property (
		go && !i_zero && i_fmt == fp_post_exc_pkg::FMT_DOUBLE && !i_mask_underflow
		|=> o_op_underflow == $past(i_exp < -18'sh003FE))
		else $error("double tiny threshold wrong");

	a_zero_not_tiny: assert property (
		go && i_zero |=> !o_op_overflow && !o_op_underflow)
		else $error("zero result flagged overflow or underflow");

	a_unf_masked_inexact: assert property (
		go && tiny && i_mask_underflow && i_inexact
		|=> o_op_underflow && o_op_precision && o_underflow_flag && o_precision_flag)
		else $error("inexact tiny under mask must set both flags");

	a_unf_denorm_sign: assert property (
		go && tiny && i_mask_underflow
		|=> o_res_write && o_res_kind == fp_post_exc_pkg::RES_DENORM
			&& o_res_sign == $past(i_sign) && o_res_exp == $past(tiny_exp))
		else $error("masked underflow result not signed denormal");

	a_unf_unmasked_exact: assert property (
		go && tiny && !i_mask_underflow && !i_inexact
		|=> o_op_underflow && o_handler_req)
		else $error("exact tiny unmasked must report underflow");

	a_masked_inexact: assert property (
		go && i_inexact && !ovf && !tiny && i_mask_precision
		|=> o_op_precision && !o_handler_req && o_res_kind == fp_post_exc_pkg::RES_ROUNDED
			&& o_res_exp == $past(i_exp) && o_res_sig == $past(i_sig))
		else $error("masked inexact must flag and store rounded value");

	a_trap_reg_flags: assert property (
		go && i_inexact && !i_dest_mem
		&& ((ovf && !i_mask_overflow) || (tiny && !i_mask_underflow))
		|=> o_op_precision && o_handler_req && (o_op_overflow || o_op_underflow))
		else $error("trapped register result must flag both and trap");

	a_vec_trap_keep: assert property (
		go && tiny && !i_mask_underflow && !i_stack_unit
		|=> !o_res_write && o_res_kind == fp_post_exc_pkg::RES_NONE && o_handler_req)
		else $error("unmasked vector underflow must keep destination");

	a_sticky_set_wins: assert property (
		go && pre_report |=> o_precision_flag)
		else $error("precision set lost to a clear");

	a_ce_freeze: assert property (
		!i_ce |=> $stable(o_res_valid) && $stable(o_res_kind)
			&& $stable({o_overflow_flag, o_underflow_flag, o_precision_flag}))
		else $error("state moved while enable low");

	c_masked_ovf: cover property (go && ovf && i_mask_overflow);
	c_masked_unf: cover property (go && tiny && i_mask_underflow && i_inexact);
	c_mem_trap: cover property (go && mem_trap);
	c_clear_race: cover property (i_ce && i_clear_flags[2] && set_flags[2]);
	c_stack_unf_trap: cover property (go && unf_trap && i_stack_unit && !i_dest_mem);

endmodule : fp_post_result_exception_check

`default_nettype wire

// >>> testbench/fp_round_src_model.sv
/*
 Stand-in for the rounding datapath that feeds the exception check.
 Assumes calls arrive just after a falling clock edge.
*/
`default_nettype none

module fp_round_src_model
(
	// completed operation
	output logic                    o_valid,
	output fp_post_exc_pkg::fmt_t   o_fmt,
	output fp_post_exc_pkg::rmode_t o_rmode,
	output logic                    o_stack_unit,
	output logic                    o_dest_mem,
	output logic                    o_sign,
	output logic                    o_zero,
	output fp_post_exc_pkg::exp_t   o_exp,
	output logic [63:0]             o_sig,
	output logic                    o_inexact
);
	timeunit 1ns;
	timeprecision 1ps;

	// b packs stack, memory dest, sign, zero, inexact
	task automatic present(input logic [1:0] f, input logic [1:0] r, input logic [4:0] b,
		input fp_post_exc_pkg::exp_t e, input logic [63:0] sg);
		o_valid = 1'b1;
		o_fmt = fp_post_exc_pkg::fmt_t'(f);
		o_rmode = fp_post_exc_pkg::rmode_t'(r);
		{o_stack_unit, o_dest_mem, o_sign, o_zero, o_inexact} = b;
		o_exp = e;
		o_sig = sg;
	endtask : present

	// fields are not held once valid drops: stale values must not look real
	task automatic withdraw();
		o_valid = 1'b0;
		o_fmt = fp_post_exc_pkg::fmt_t'(~o_fmt);
		o_rmode = fp_post_exc_pkg::rmode_t'(~o_rmode);
		{o_stack_unit, o_dest_mem, o_sign, o_zero, o_inexact} =
			~{o_stack_unit, o_dest_mem, o_sign, o_zero, o_inexact};
		o_exp = ~o_exp;
		o_sig = ~o_sig;
	endtask : withdraw

	initial
	begin
		present(2'h0, 2'h0, 5'h00, 18'sh00000, 64'h0);
		o_valid = 1'b0;
	end

endmodule : fp_round_src_model

`default_nettype wire

// >>> testbench/tb_fp_post_result_exception_check.sv
/*
 Self-checking bench for the post-result exception check.
 Assumes the partner model presents operations; masks, clears and enable come from here.
*/
`default_nettype none

module tb_fp_post_result_exception_check;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		fp_post_exc_pkg::res_kind_t kind;
		logic                       wr, ov, un, pr, hq, cc, sgchk;
		fp_post_exc_pkg::exp_t      ex;
		logic [63:0]                sg;
	} expect_t;

	localparam fp_post_exc_pkg::exp_t OVT [4] = '{fp_post_exc_pkg::OVF_EXP_HALF, fp_post_exc_pkg::OVF_EXP_SINGLE,
		fp_post_exc_pkg::OVF_EXP_DOUBLE, fp_post_exc_pkg::OVF_EXP_EXT};
	localparam fp_post_exc_pkg::exp_t TNT [4] = '{fp_post_exc_pkg::TINY_EXP_HALF, fp_post_exc_pkg::TINY_EXP_SINGLE,
		fp_post_exc_pkg::TINY_EXP_DOUBLE, fp_post_exc_pkg::TINY_EXP_EXT};

	logic                           i_clk     = 1'b0;
	logic                           i_reset_n = 1'b0;
	logic                           i_ce      = 1'b1;
	logic                           mo        = 1'b1;
	logic                           mu        = 1'b1;
	logic                           mp        = 1'b1;
	logic [2:0]                     clr       = 3'h0;
	logic [2:0]                     sticky    = 3'h0;
	logic [1:0]                     f, r;
	logic [4:0]                     b;
	fp_post_exc_pkg::exp_t          e, re;
	logic [63:0]                    sg;
	int                             err_count = 0;
	int                             checked   = 0;
	int                             seed      = 87543;
	int                             cyc       = 0;
	int                             k, j, n;
	wire logic                      op_valid, op_stack, op_mem, op_sign, op_zero, op_inexact;
	wire fp_post_exc_pkg::fmt_t     op_fmt;
	wire fp_post_exc_pkg::rmode_t   op_rmode;
	wire fp_post_exc_pkg::exp_t     op_exp, o_res_exp;
	wire logic [63:0]               op_sig, o_res_sig;
	wire logic                      o_res_valid, o_res_write, o_res_sign, o_op_overflow, o_op_underflow;
	wire logic                      o_op_precision, o_handler_req, o_clear_cond_code_bit_one;
	wire logic                      o_overflow_flag, o_underflow_flag, o_precision_flag;
	wire fp_post_exc_pkg::res_kind_t o_res_kind;

	always #5 i_clk = ~i_clk;

	fp_round_src_model i_fp_round_src_model (.o_valid(op_valid), .o_fmt(op_fmt), .o_rmode(op_rmode),
		.o_stack_unit(op_stack), .o_dest_mem(op_mem), .o_sign(op_sign), .o_zero(op_zero), .o_exp(op_exp),
		.o_sig(op_sig), .o_inexact(op_inexact));

	fp_post_result_exception_check i_fp_post_result_exception_check (.i_clk(i_clk), .i_reset_n(i_reset_n),
		.i_ce(i_ce), .i_valid(op_valid), .i_fmt(op_fmt), .i_rmode(op_rmode), .i_stack_unit(op_stack),
		.i_dest_mem(op_mem), .i_sign(op_sign), .i_zero(op_zero), .i_exp(op_exp), .i_sig(op_sig),
		.i_inexact(op_inexact), .i_mask_overflow(mo), .i_mask_underflow(mu), .i_mask_precision(mp),
		.i_clear_flags(clr), .o_res_valid(o_res_valid), .o_res_write(o_res_write), .o_res_kind(o_res_kind),
		.o_res_sign(o_res_sign), .o_res_exp(o_res_exp), .o_res_sig(o_res_sig), .o_op_overflow(o_op_overflow),
		.o_op_underflow(o_op_underflow), .o_op_precision(o_op_precision), .o_handler_req(o_handler_req),
		.o_clear_cond_code_bit_one(o_clear_cond_code_bit_one), .o_overflow_flag(o_overflow_flag),
		.o_underflow_flag(o_underflow_flag), .o_precision_flag(o_precision_flag));

	task automatic results();
		if (err_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results

	task automatic chk_bit(input logic got, input logic want);
		checked++;
		if (got !== want)
		begin
			err_count++;
			$display("ERROR %0t flag got %b want %b", $time, got, want);
		end
	endtask : chk_bit

	task automatic chk_val(input logic [63:0] got, input logic [63:0] want);
		checked++;
		if (got !== want)
		begin
			err_count++;
			$display("ERROR %0t value got %h want %h", $time, got, want);
		end
	endtask : chk_val

	function automatic expect_t calc();
		expect_t x;
		logic    ovf, tiny, trap, inf;
		x = '0;
		ovf = !b[1] && (e >= OVT[f]);
		tiny = !b[1] && (e < TNT[f]);
		x.ov = ovf;
		x.un = tiny && (!mu || b[0]);
		trap = (ovf && !mo) || (x.un && !mu);
		x.pr = b[0] && !(trap && b[3]);
		x.hq = trap || (x.pr && !mp);
		x.cc = trap && b[3];
		x.wr = 1'b1;
		x.ex = e;
		x.sg = sg;
		x.sgchk = 1'b1;
		x.kind = fp_post_exc_pkg::RES_ROUNDED;
		if (trap)
		begin
			x.wr = b[4] && !b[3];
			x.kind = x.wr ? fp_post_exc_pkg::RES_BIASED : fp_post_exc_pkg::RES_NONE;
			x.ex = ovf ? e - fp_post_exc_pkg::BIAS_ADJ_DEFAULT : e + fp_post_exc_pkg::BIAS_ADJ_DEFAULT;
			x.sgchk = 1'b0;
		end
		else if (ovf)
		begin
			inf = (r == 2'h0) || (r == 2'h1 && b[2]) || (r == 2'h2 && !b[2]);
			x.kind = inf ? fp_post_exc_pkg::RES_INF : fp_post_exc_pkg::RES_MAX_FINITE;
			x.ex = inf ? OVT[f] : OVT[f] - 18'sh00001;
			x.sg = inf ? 64'h0 : '1;
		end
		else if (tiny)
		begin
			x.kind = fp_post_exc_pkg::RES_DENORM;
			x.ex = TNT[f];
			x.sg = (TNT[f] - e >= 18'sh00040) ? 64'h0 : sg >> (TNT[f] - e);
		end
		return x;
	endfunction : calc

	// clear bits ride with the op; set wins over clear at the same edge
	task automatic do_op(input logic [1:0] fa, input logic [1:0] ra, input logic [4:0] ba,
		input fp_post_exc_pkg::exp_t ea, input logic [63:0] sga, input logic [2:0] ca, input logic b2b);
		expect_t x;
		f = fa;
		r = ra;
		b = ba;
		e = ea;
		sg = sga;
		clr = ca;
		x = calc();
		i_fp_round_src_model.present(fa, ra, ba, ea, sga);
		@(negedge i_clk);
		sticky = (sticky & ~ca) | {x.pr, x.un, x.ov};
		chk_bit(o_res_valid, 1'b1);
		chk_bit(o_op_overflow, x.ov);
		chk_bit(o_op_underflow, x.un);
		chk_bit(o_op_precision, x.pr);
		chk_bit(o_handler_req, x.hq);
		chk_bit(o_clear_cond_code_bit_one, x.cc);
		chk_bit(o_res_write, x.wr);
		chk_val(o_res_kind, x.kind);
		if (x.wr && !b[1]) chk_val(o_res_exp, x.ex);
		if (x.wr && x.sgchk) chk_val(o_res_sig, x.sg);
		if (x.wr) chk_bit(o_res_sign, b[2]);
		chk_val({o_precision_flag, o_underflow_flag, o_overflow_flag}, sticky);
		// gap cycle with scrambled fields, so stale inputs cannot pass
		if (!b2b)
		begin
			i_fp_round_src_model.withdraw();
			clr = 3'h0;
			@(negedge i_clk);
		end
	endtask : do_op

	always @(posedge i_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_count++;
			results();
		end
	end

	initial
	begin
		repeat (4) @(negedge i_clk);
		i_reset_n = 1'b1;
		chk_val({o_precision_flag, o_underflow_flag, o_overflow_flag}, 3'h0);
		// every rounding mode and sign, back to back
		for (k = 0; k < 8; k++)
			do_op(2'h1, k[2:1], {2'h0, k[0], 2'h0}, fp_post_exc_pkg::OVF_EXP_SINGLE, 64'h0, 3'h0, k != 7);
		// each format on both sides of both thresholds
		for (k = 0; k < 16; k++)
			do_op(k[3:2], 2'h0, {4'h0, k[0]}, (k[1] ? TNT[k[3:2]] : OVT[k[3:2]]) - 18'(k[0]),
				{1'b1, 63'($random(seed))}, 3'h0, 1'b0);
		{mo, mu, mp} = 3'h0;
		for (k = 0; k < 16; k++)
			do_op(2'h2, 2'h3, {k[1:0], 2'h0, k[3]}, k[2] ? OVT[2] : TNT[2] - 18'sh00001,
				{1'b1, 63'($random(seed))}, 3'h0, 1'b0);
		{mo, mu, mp} = 3'h7;
		do_op(2'h0, 2'h0, 5'h01, 18'sh00000, 64'h8000000000000000, 3'h7, 1'b0);
		@(negedge i_clk);
		chk_bit(o_res_valid, 1'b0);
		// with the enable low an op and a clear are both ignored
		i_ce = 1'b0;
		i_fp_round_src_model.present(2'h1, 2'h0, 5'h01, OVT[1], 64'h0);
		clr = 3'h7;
		@(negedge i_clk);
		i_fp_round_src_model.withdraw();
		clr = 3'h0;
		i_ce = 1'b1;
		chk_bit(o_res_valid, 1'b0);
		chk_val({o_precision_flag, o_underflow_flag, o_overflow_flag}, sticky);
		// mid-run reset drops every flag and pulse
		i_reset_n = 1'b0;
		repeat (2) @(negedge i_clk);
		i_reset_n = 1'b1;
		sticky = 3'h0;
		chk_bit(o_res_valid, 1'b0);
		chk_val({o_precision_flag, o_underflow_flag, o_overflow_flag}, sticky);
		for (n = 0; n < 400; n++)
		begin
			k = $random(seed);
			j = $random(seed) % 3;
			re = (k[1:0] == 2'h0) ? OVT[k[3:2]] : (k[1:0] == 2'h1) ? TNT[k[3:2]] : k[31:26];
			{mo, mu, mp} = k[14:12];
			do_op(k[3:2], k[5:4], {k[10:8], k[19:16] == 4'h0, k[11]}, re + 18'(j),
				{1'b1, 63'($random(seed))}, (k[22:20] == 3'h0) ? k[25:23] : 3'h0, k[15]);
		end
		results();
	end

endmodule : tb_fp_post_result_exception_check

`default_nettype wire
